//--- hdl/tdhd_defs.svh
`ifndef TDHD_DEFS_SVH
`define TDHD_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TDHD_OFS_OUT0_SD_SWING 8'h2b
`define TDHD_OFS_OUT1_HD_BOOST 8'h2c
`define TDHD_OFS_OUT1_HD_SWING 8'h2d

// ----------------------------------------
// reset values of whole registers and of the applied swing outputs
// ----------------------------------------
`define TDHD_RST_OUT0_SD_SWING 16'h1170
`define TDHD_RST_OUT1_HD_BOOST 16'h0201
`define TDHD_RST_OUT1_HD_SWING 16'h1170
`define TDHD_RST_OUT0_APPLIED 6'h11
`define TDHD_RST_OUT1_APPLIED_SWING 6'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define TDHD_WIDTH_MSB 12
`define TDHD_WIDTH_LSB 8
`define TDHD_PWROFF_BIT 6
`define TDHD_AMPL_MSB 5
`define TDHD_AMPL_LSB 0
`define TDHD_SWING_MSB 13
`define TDHD_SWING_LSB 8

// ----------------------------------------
// field upper limits
// ----------------------------------------
`define TDHD_WIDTH_MAX 5'h0f
`define TDHD_AMPL_MAX 6'h32
`define TDHD_SWING_MAX 6'h28

`endif

//--- hdl/tdhd_pkg.sv
package tdhd_pkg;

	// pre-emphasis settings of one driver
	typedef struct packed {
		logic [4:0] pulseWidth;
		logic powerOff;
		logic [5:0] amplitude;
	} tdhd_boost_t;

	// register port request
	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [7:0] addr;
		logic [15:0] wrData;
	} tdhd_req_t;

	// register index inside the bank
	typedef enum logic [1:0] {
		TDHD_R_SD_SWING,
		TDHD_R_HD_BOOST,
		TDHD_R_HD_SWING,
		TDHD_R_NONE
	} tdhd_sel_t;

endpackage

//--- hdl/tdhd_word_reg.sv
`timescale 1ns/1ps
// one 16-bit register word with its own reset value
module tdhd_word_reg #(
	parameter logic [15:0] RESET_VALUE = 16'h0000
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic load,
	input wire logic [15:0] nextWord,
	output logic [15:0] word
);

	// whole word updated in one edge
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			word <= RESET_VALUE;
		end else if (load) begin
			word <= nextWord; // [RQ8]
		end
	end

endmodule

//--- hdl/tdhd_config_regs.sv
`timescale 1ns/1ps
`include "tdhd_defs.svh"
// Contract
// RQ1: out1 HD pulse width, bits 12:8, reset 2
// RQ2: bit 6 powers down out1 HD pre-emphasis
// RQ3: out1 HD amplitude, bits 5:0, reset 1
// RQ4: out1 HD swing, bits 13:8, reset 11h
// RQ5: out0 SD swing at 2Bh, reset 11h
// RQ6: SD settings apply unless per-rate select
// RQ7: host writes reserved bits back unchanged
// RQ8: 16-bit registers, whole-word write, readback
module tdhd_config_regs (
	input wire logic core_clk,
	input wire logic rstn,
	input tdhd_pkg::tdhd_req_t req,
	output logic [15:0] rdData,
	output logic rdValid,
	input wire logic out0RateSpecificSelect,
	input wire logic out1RateSpecificSelect,
	input wire logic hdRateActive,
	input wire logic sdRateActive,
	input wire logic [5:0] out0OtherRateSwing,
	input tdhd_pkg::tdhd_boost_t out1SdBoost,
	input wire logic [5:0] out1SdSwing,
	output logic [5:0] out0AppliedSwing,
	output tdhd_pkg::tdhd_boost_t out1AppliedBoost,
	output logic [5:0] out1AppliedSwing
);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	tdhd_pkg::tdhd_sel_t sel;
	logic [15:0] word [3];
	logic [15:0] next_word [3];
	logic [2:0] load;

	// map the request address to a register
	// every other offset selects nothing
	always_comb begin
		unique case (req.addr)
			`TDHD_OFS_OUT0_SD_SWING: sel = tdhd_pkg::TDHD_R_SD_SWING;
			`TDHD_OFS_OUT1_HD_BOOST: sel = tdhd_pkg::TDHD_R_HD_BOOST;
			`TDHD_OFS_OUT1_HD_SWING: sel = tdhd_pkg::TDHD_R_HD_SWING;
			default: sel = tdhd_pkg::TDHD_R_NONE;
		endcase
	end

	// ----------------------------------------
	// write data shaping
	// ----------------------------------------
	logic [4:0] wrWidth;
	logic [5:0] wrAmpl;
	logic [5:0] wrSwing;
	// field values after the top-code clamp
	logic [4:0] clampWidth;
	logic [5:0] clampAmpl;
	logic [5:0] clampSwing;

	// raw field slices of the incoming word
	assign wrWidth = req.wrData[`TDHD_WIDTH_MSB:`TDHD_WIDTH_LSB];
	assign wrAmpl = req.wrData[`TDHD_AMPL_MSB:`TDHD_AMPL_LSB];
	assign wrSwing = req.wrData[`TDHD_SWING_MSB:`TDHD_SWING_LSB];

	// pulse width above its top code is held at the top code
	always_comb begin
		if (wrWidth > `TDHD_WIDTH_MAX) begin
			clampWidth = `TDHD_WIDTH_MAX; // [RQ1]
		end else begin
			clampWidth = wrWidth;
		end
	end

	// amplitude above its top code is held at the top code
	always_comb begin
		if (wrAmpl > `TDHD_AMPL_MAX) begin
			clampAmpl = `TDHD_AMPL_MAX; // [RQ3]
		end else begin
			clampAmpl = wrAmpl;
		end
	end

	// swing above its top code is held at the top code
	always_comb begin
		if (wrSwing > `TDHD_SWING_MAX) begin
			clampSwing = `TDHD_SWING_MAX; // [RQ4] [RQ5]
		end else begin
			clampSwing = wrSwing;
		end
	end

	// reserved bits pass through as written; the host writes back
	// what it read, so they act as plain storage
	always_comb begin
		next_word[0] = req.wrData;
		next_word[0][`TDHD_SWING_MSB:`TDHD_SWING_LSB] = clampSwing; // [RQ5]
		next_word[1] = req.wrData;
		next_word[1][`TDHD_WIDTH_MSB:`TDHD_WIDTH_LSB] = clampWidth; // [RQ1]
		next_word[1][`TDHD_AMPL_MSB:`TDHD_AMPL_LSB] = clampAmpl; // [RQ3]
		next_word[2] = req.wrData;
		next_word[2][`TDHD_SWING_MSB:`TDHD_SWING_LSB] = clampSwing; // [RQ4]
	end

	// ----------------------------------------
	// register words
	// ----------------------------------------
	localparam logic [15:0] RESETS [3] = '{
		`TDHD_RST_OUT0_SD_SWING,
		`TDHD_RST_OUT1_HD_BOOST,
		`TDHD_RST_OUT1_HD_SWING
	};

	// one word per register, loaded by a decoded write
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_word
			assign load[i] = req.wrEn && (sel == tdhd_pkg::tdhd_sel_t'(i));
			tdhd_word_reg #(
				.RESET_VALUE(RESETS[i])
			) u_word (
				.core_clk(core_clk),
				.rstn(rstn),
				.load(load[i]), // [RQ8]
				.nextWord(next_word[i]),
				.word(word[i])
			);
		end
	endgenerate

	// ----------------------------------------
	// read port
	// ----------------------------------------
	logic [15:0] rdMux;

	// select the addressed word, unmapped addresses give zero
	always_comb begin
		unique case (sel)
			tdhd_pkg::TDHD_R_SD_SWING: rdMux = word[0]; // [RQ8]
			tdhd_pkg::TDHD_R_HD_BOOST: rdMux = word[1];
			tdhd_pkg::TDHD_R_HD_SWING: rdMux = word[2];
			tdhd_pkg::TDHD_R_NONE: rdMux = 16'h0000;
		endcase
	end

	// registered readback, held until the next read
	// a read and a write in one cycle return the old word
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdData <= 16'h0000;
		end else if (req.rdEn) begin
			rdData <= rdMux; // [RQ8]
		end
	end

	// read answer strobe one cycle after the request
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			rdValid <= 1'b0;
		end else begin
			rdValid <= req.rdEn;
		end
	end

	// ----------------------------------------
	// field views
	// ----------------------------------------
	tdhd_pkg::tdhd_boost_t hdBoost;
	logic [5:0] hdSwing;
	logic [5:0] sdSwing0;

	// named fields of the stored words
	assign hdBoost.pulseWidth =
		word[1][`TDHD_WIDTH_MSB:`TDHD_WIDTH_LSB]; // [RQ1]
	assign hdBoost.powerOff = word[1][`TDHD_PWROFF_BIT]; // [RQ2]
	assign hdBoost.amplitude =
		word[1][`TDHD_AMPL_MSB:`TDHD_AMPL_LSB]; // [RQ3]
	assign hdSwing = word[2][`TDHD_SWING_MSB:`TDHD_SWING_LSB]; // [RQ4]
	assign sdSwing0 = word[0][`TDHD_SWING_MSB:`TDHD_SWING_LSB]; // [RQ5]

	// ----------------------------------------
	// applied driver settings
	// ----------------------------------------
	logic out0UseOther;
	logic out1UseHd;

	// the select and rate levels come from logic on this clock,
	// so they feed the choice without a synchroniser
	assign out0UseOther = out0RateSpecificSelect && !sdRateActive; // [RQ6]
	assign out1UseHd = out1RateSpecificSelect && hdRateActive; // [RQ6]

	// output0 swing, sd value unless a per-rate value is chosen
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			out0AppliedSwing <= `TDHD_RST_OUT0_APPLIED;
		end else if (out0UseOther) begin
			out0AppliedSwing <= out0OtherRateSwing; // [RQ6]
		end else begin
			out0AppliedSwing <= sdSwing0; // [RQ6]
		end
	end

	// output1 pre-emphasis, hd fields only at hd rate with select on
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			out1AppliedBoost <= '0;
		end else if (out1UseHd) begin
			out1AppliedBoost <= hdBoost; // [RQ6]
		end else begin
			out1AppliedBoost <= out1SdBoost; // [RQ6]
		end
	end

	// output1 swing, follows the same choice as its pre-emphasis
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			out1AppliedSwing <= `TDHD_RST_OUT1_APPLIED_SWING;
		end else if (out1UseHd) begin
			out1AppliedSwing <= hdSwing; // [RQ6]
		end else begin
			out1AppliedSwing <= out1SdSwing; // [RQ6]
		end
	end

endmodule

//--- tb/tdhd_config_regs_sva.sv
`timescale 1ns/1ps
// ------------------------------
// port checker
// ------------------------------
module tdhd_chk (
	input wire logic core_clk,
	input wire logic rstn,
	input tdhd_pkg::tdhd_req_t req,
	input wire logic [15:0] rdData,
	input wire logic rdValid,
	input wire logic out0RateSpecificSelect,
	input wire logic out1RateSpecificSelect,
	input wire logic hdRateActive,
	input wire logic sdRateActive,
	input wire logic [5:0] out0OtherRateSwing,
	input tdhd_pkg::tdhd_boost_t out1SdBoost,
	input wire logic [5:0] out1SdSwing,
	input wire logic [5:0] out0AppliedSwing,
	input tdhd_pkg::tdhd_boost_t out1AppliedBoost,
	input wire logic [5:0] out1AppliedSwing
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// hd fields in use on output1
	wire logic hdSel = out1RateSpecificSelect && hdRateActive;
	sequence s_wr;
		req.wrEn && req.addr == 8'h2c && req.wrData == 16'h0305;
	endsequence
	sequence s_rd;
		req.rdEn && !req.wrEn && req.addr == 8'h2c;
	endsequence
	property p_rv; req.rdEn |=> rdValid; endproperty
	a_rv: assert property (p_rv) else $error("no rdValid");
	property p_rvlo; !req.rdEn |=> !rdValid; endproperty
	a_rvlo: assert property (p_rvlo) else $error("rdValid stuck");
	property p_hold; !req.rdEn |=> $stable(rdData); endproperty
	a_hold: assert property (p_hold) else $error("rdData moved");
	property p_un; req.rdEn && (req.addr < 8'h2b || req.addr > 8'h2d)
		|=> rdData == 16'h0000; endproperty
	a_un: assert property (p_un) else $error("unmapped read");
	property p_wr; s_wr ##1 s_rd |=> rdData == 16'h0305; endproperty
	a_wr: assert property (p_wr) else $error("readback");
	property p_off; req.wrEn && req.addr == 8'h2c && req.wrData[6]
		##1 (hdSel && !req.wrEn) [*2] |=> out1AppliedBoost.powerOff;
	endproperty
	a_off: assert property (p_off) else $error("power off");
	property p_sd; !out1RateSpecificSelect |=> out1AppliedBoost ==
		$past(out1SdBoost) && out1AppliedSwing == $past(out1SdSwing);
	endproperty
	a_sd: assert property (p_sd) else $error("sd default");
	property p_o0; out0RateSpecificSelect && !sdRateActive
		|=> out0AppliedSwing == $past(out0OtherRateSwing); endproperty
	a_o0: assert property (p_o0) else $error("out0 rate");
	property p_lim; hdSel |=> out1AppliedBoost.amplitude <= 6'h32 &&
		out1AppliedBoost.pulseWidth <= 5'h0f && out1AppliedSwing <= 6'h28;
	endproperty
	a_lim: assert property (p_lim) else $error("limit");
endmodule
bind tdhd_config_regs tdhd_chk u_chk (
	.core_clk(core_clk),
	.rstn(rstn),
	.req(req),
	.rdData(rdData),
	.rdValid(rdValid),
	.out0RateSpecificSelect(out0RateSpecificSelect),
	.out1RateSpecificSelect(out1RateSpecificSelect),
	.hdRateActive(hdRateActive),
	.sdRateActive(sdRateActive),
	.out0OtherRateSwing(out0OtherRateSwing),
	.out1SdBoost(out1SdBoost),
	.out1SdSwing(out1SdSwing),
	.out0AppliedSwing(out0AppliedSwing),
	.out1AppliedBoost(out1AppliedBoost),
	.out1AppliedSwing(out1AppliedSwing)
);

//--- tb/tb_tdhd_config_regs.sv
`timescale 1ns/1ps
module tb_tdhd_config_regs;
	logic core_clk = '0, rstn = '0, rdValid;
	tdhd_pkg::tdhd_req_t req = '0;
	logic [15:0] rdData;
	logic out0RateSpecificSelect = '0, out1RateSpecificSelect = '1;
	logic hdRateActive = '1, sdRateActive = '0;
	logic [5:0] out0OtherRateSwing = '0, out1SdSwing = '0;
	logic [5:0] out0AppliedSwing, out1AppliedSwing;
	tdhd_pkg::tdhd_boost_t out1SdBoost = '0, out1AppliedBoost;
	int errTotal = 0, testsRun = 0;
	int mdl[3] = '{16'h1170, 16'h0201, 16'h1170};
	tdhd_config_regs uut (
		.core_clk(core_clk),
		.rstn(rstn),
		.req(req),
		.rdData(rdData),
		.rdValid(rdValid),
		.out0RateSpecificSelect(out0RateSpecificSelect),
		.out1RateSpecificSelect(out1RateSpecificSelect),
		.hdRateActive(hdRateActive),
		.sdRateActive(sdRateActive),
		.out0OtherRateSwing(out0OtherRateSwing),
		.out1SdBoost(out1SdBoost),
		.out1SdSwing(out1SdSwing),
		.out0AppliedSwing(out0AppliedSwing),
		.out1AppliedBoost(out1AppliedBoost),
		.out1AppliedSwing(out1AppliedSwing)
	);
	always #12.5 core_clk = ~core_clk;
	// model of a stored write with saturation
	function automatic int lim(int d, int a);
		int f;
		f = (d >> 8) & 8'h3f;
		if (a != 8'h2c && f > 8'h28) d = (d & 16'hc0ff) | 16'h2800;
		if (a == 8'h2c && (f & 8'h1f) > 8'h0f) d = (d & 16'he0ff) | 16'h0f00;
		if (a == 8'h2c && (d & 8'h3f) > 8'h32) d = (d & 16'hffc0) | 16'h0032;
		return d;
	endfunction
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		testsRun++;
		if (s !== e) begin
			errTotal++;
			$display("ERROR %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [15:0] d);
		req = '{1'h1, 1'h0, a, d};
		@(posedge core_clk) #1;
		if (a > 8'h2a && a < 8'h2e) mdl[a - 8'h2b] = lim(d, a);
	endtask
	task automatic rd(logic [7:0] a);
		logic [15:0] e;
		e = (a > 8'h2a && a < 8'h2e) ? 16'(mdl[a - 8'h2b]) : 16'h0000;
		req = '{1'h0, 1'h1, a, req.wrData};
		@(posedge core_clk) #1;
		chk("rdValid", {15'h0, rdValid}, 16'h0001);
		chk("rdData", rdData, e);
	endtask
	// host write that writes reserved bits back unchanged
	task automatic wrKeep(logic [7:0] a, logic [15:0] d);
		logic [15:0] m;
		m = (a == 8'h2c) ? 16'h1f7f : 16'h3f00;
		if (a > 8'h2a && a < 8'h2e)
			d = (d & m) | (16'(mdl[a - 8'h2b]) & ~m);
		wr(a, d);
	endtask
	// random selects, then compare applied settings
	task automatic app();
		logic [15:0] b, eB, eS1, eS0;
		logic useHd, useOther;
		b = 16'(mdl[1]);
		req = '{1'h0, 1'h0, req.addr, req.wrData};
		{out0RateSpecificSelect, out1RateSpecificSelect, hdRateActive,
			sdRateActive, out0OtherRateSwing, out1SdSwing,
			out1SdBoost} = 28'($urandom);
		useHd = out1RateSpecificSelect && hdRateActive;
		useOther = out0RateSpecificSelect && !sdRateActive;
		eB = useHd ? 16'({b[12:8], b[6], b[5:0]}) : 16'(out1SdBoost);
		eS1 = useHd ? 16'((mdl[2] >> 8) & 16'h003f) : 16'(out1SdSwing);
		eS0 = useOther ? 16'(out0OtherRateSwing) : 16'((mdl[0] >> 8) & 16'h003f);
		repeat (2) @(posedge core_clk);
		#1;
		chk("boost", 16'(out1AppliedBoost), eB);
		chk("swing1", 16'(out1AppliedSwing), eS1);
		chk("swing0", 16'(out0AppliedSwing), eS0);
		chk("rdValid idle", {15'h0, rdValid}, 16'h0000);
	endtask
	task automatic printVerdict();
		if (errTotal == 0 && testsRun > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		#60000;
		errTotal++;
		printVerdict();
	end
	// main sequence
	initial begin
		void'($urandom(70206));
		repeat (3) @(posedge core_clk);
		#1 rstn = '1;
		for (int a = 8'h2a; a < 8'h2f; a++) rd(8'(a));
		wr(8'h2c, 16'h0305);
		rd(8'h2c);
		wr(8'h2c, 16'h1f7f);
		rd(8'h2c);
		rd(8'h2c);
		repeat (60) begin
			app();
			wrKeep(8'h2a + 8'($urandom % 5), 16'($urandom));
			rd(8'h2a + 8'($urandom % 5));
		end
		printVerdict();
	end
endmodule
